// ### hw/dsp_operand_addressing_repeat.sv
// Operand address generation, prefetch and repeat control of the DSP core
`timescale 1ns/1ps
module dsp_operand_addressing_repeat (
  input wire logic ref_clk, // Core clock, 50 MHz
  input wire logic srst, // Synchronous reset, active high
  input wire logic instr_valid, // Decoded instruction offered
  input wire logic [15:0] instr_word, // First instruction word
  input wire logic [15:0] instr_ext_word, // Second word of a two-word instruction
  input wire logic [2:0] addr_mode, // Addressing mode of the instruction
  input wire logic is_repeat, // Instruction is repeat_instr
  input wire logic operand_ext, // Operand fetch targets external memory
  input wire logic page_load, // Load data_page_pointer
  input wire logic [8:0] page_value, // New page pointer value
  input wire logic [15:0] mem_rdata, // Data memory word, in the same cycle as data_addr
  input wire logic irq_req_pin, // Maskable interrupt request, asynchronous
  input wire logic nmi_req_pin, // Nonmaskable interrupt request, asynchronous
  output logic instr_ready, // Can take an instruction this cycle
  output logic fetch_req, // Prefetch of the next instruction
  output logic [15:0] prog_addr, // Address of the instruction to prefetch
  output logic [15:0] data_addr, // Data operand address
  output logic data_addr_valid, // data_addr is meaningful
  output logic [15:0] imm_operand, // Immediate operand
  output logic imm_valid, // imm_operand is meaningful
  output logic iter_issue, // One execution of an instruction issued
  output logic [15:0] repeat_count_reg, // Repeat counter
  output logic repeat_active, // Repeat sequence under way
  output logic [2:0] aux_select_pointer, // Selected auxiliary register
  output logic [8:0] data_page_pointer, // Data page pointer
  output logic irq_grant, // Maskable interrupt taken
  output logic nmi_grant // Nonmaskable interrupt taken
);

  function automatic logic [15:0] rev16(input logic [15:0] v);
    logic [15:0] r;
    r = '0;
    for (int i = 0; i < 16; i++) begin
      r[i] = v[15-i];
    end
    return r;
  endfunction : rev16

  dsp_addr_pkg::seq_state_t state_r, state_nxt;
  logic [15:0] aux_r [dsp_addr_pkg::NUM_AUX];
  logic [15:0] aux_nxt [dsp_addr_pkg::NUM_AUX];
  logic [2:0] sel_r, sel_nxt;
  logic [8:0] page_r, page_nxt;
  logic [15:0] count_r, count_nxt;
  logic [15:0] pc_r, pc_nxt;
  logic [1:0] wait_r, wait_nxt;
  logic [15:0] held_word_r, held_word_nxt;
  logic [2:0] held_mode_r, held_mode_nxt;
  logic held_ext_r, held_ext_nxt;
  logic ready_r, ready_nxt;
  logic fetch_r, fetch_nxt;
  logic [15:0] daddr_r, daddr_nxt;
  logic dvalid_r, dvalid_nxt;
  logic [15:0] imm_r, imm_nxt;
  logic ivalid_r, ivalid_nxt;
  logic issue_r, issue_nxt;
  logic active_r, active_nxt;
  logic irq_g_r, irq_g_nxt;
  logic nmi_g_r, nmi_g_nxt;
  logic irq_s1_r, irq_s2_r, nmi_s1_r, nmi_s2_r;

  logic accept, loop_issue, issue;
  logic [15:0] cur_word, cur_aux, mod_aux;
  logic [2:0] cur_mode, cur_op;
  logic cur_ext;

  always_comb begin
    accept = instr_valid && ready_r;
    loop_issue = (state_r == dsp_addr_pkg::ST_LOOP) && (wait_r == 2'h0);
    issue = accept || loop_issue;
    cur_word = accept ? instr_word : held_word_r;
    cur_mode = accept ? addr_mode : held_mode_r;
    cur_ext = accept ? operand_ext : held_ext_r;
    cur_op = cur_word[dsp_addr_pkg::IND_OP_LSB +: dsp_addr_pkg::OP_W];
    cur_aux = aux_r[sel_r];
    // Same-cycle auxiliary arithmetic
    case (dsp_addr_pkg::ind_op_t'(cur_op))
      dsp_addr_pkg::IND_INC: mod_aux = cur_aux + dsp_addr_pkg::AUX_STEP;
      dsp_addr_pkg::IND_DEC: mod_aux = cur_aux - dsp_addr_pkg::AUX_STEP;
      dsp_addr_pkg::IND_ADD0: mod_aux = cur_aux + aux_r[0];
      dsp_addr_pkg::IND_SUB0: mod_aux = cur_aux - aux_r[0];
      dsp_addr_pkg::IND_REV_ADD0: mod_aux = rev16(rev16(cur_aux) + rev16(aux_r[0]));
      dsp_addr_pkg::IND_REV_SUB0: mod_aux = rev16(rev16(cur_aux) - rev16(aux_r[0]));
      default: mod_aux = cur_aux;
    endcase
  end

  // Operand path: addresses, immediates, auxiliary registers, page pointer
  always_comb begin
    aux_nxt = aux_r;
    sel_nxt = sel_r;
    page_nxt = page_load ? page_value : page_r;
    daddr_nxt = daddr_r;
    dvalid_nxt = 1'b0;
    imm_nxt = imm_r;
    ivalid_nxt = 1'b0;
    issue_nxt = 1'b0;
    pc_nxt = pc_r;
    fetch_nxt = 1'b0;
    if (issue) begin
      issue_nxt = !(accept && is_repeat);
      case (dsp_addr_pkg::addr_mode_t'(cur_mode))
        dsp_addr_pkg::MODE_DIRECT: begin
          daddr_nxt = {page_r, cur_word[dsp_addr_pkg::OFS_LSB +: dsp_addr_pkg::OFS_W]};
          dvalid_nxt = 1'b1;
        end
        dsp_addr_pkg::MODE_INDIRECT: begin
          daddr_nxt = cur_aux;
          dvalid_nxt = 1'b1;
          aux_nxt[sel_r] = mod_aux;
          if (cur_word[dsp_addr_pkg::SEL_LOAD_BIT]) begin
            sel_nxt = cur_word[dsp_addr_pkg::NEXT_SEL_LSB +: dsp_addr_pkg::SEL_W];
          end
        end
        dsp_addr_pkg::MODE_SHORT_IMM: begin
          imm_nxt = {8'h00, cur_word[dsp_addr_pkg::SHORT_IMM_LSB +: dsp_addr_pkg::SHORT_IMM_W]};
          ivalid_nxt = 1'b1;
        end
        dsp_addr_pkg::MODE_LONG_IMM: begin
          imm_nxt = instr_ext_word;
          ivalid_nxt = 1'b1;
        end
        default: begin
          dvalid_nxt = 1'b0;
        end
      endcase
    end
    if (accept) begin
      // Word count by form; next instruction fetched during this one
      pc_nxt = pc_r + ((addr_mode == dsp_addr_pkg::MODE_LONG_IMM) ?
                       dsp_addr_pkg::TWO_WORDS : dsp_addr_pkg::ONE_WORD);
      fetch_nxt = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      for (int i = 0; i < dsp_addr_pkg::NUM_AUX; i++) begin
        aux_r[i] <= 16'h0000;
      end
      sel_r <= 3'h0;
      page_r <= dsp_addr_pkg::PAGE_RST;
      daddr_r <= 16'h0000;
      dvalid_r <= 1'b0;
      imm_r <= 16'h0000;
      ivalid_r <= 1'b0;
      issue_r <= 1'b0;
      pc_r <= dsp_addr_pkg::PC_RST;
      fetch_r <= 1'b0;
    end else begin
      aux_r <= aux_nxt;
      sel_r <= sel_nxt;
      page_r <= page_nxt;
      daddr_r <= daddr_nxt;
      dvalid_r <= dvalid_nxt;
      imm_r <= imm_nxt;
      ivalid_r <= ivalid_nxt;
      issue_r <= issue_nxt;
      pc_r <= pc_nxt;
      fetch_r <= fetch_nxt;
    end
  end

  // Repeat sequencer, external wait and interrupt masking
  always_comb begin
    state_nxt = state_r;
    count_nxt = count_r;
    held_word_nxt = held_word_r;
    held_mode_nxt = held_mode_r;
    held_ext_nxt = held_ext_r;
    wait_nxt = (wait_r != 2'h0) ? wait_r - 2'h1 : 2'h0;
    if (issue && cur_ext) begin
      wait_nxt = dsp_addr_pkg::EXT_WAIT_CYC;
    end
    case (state_r)
      dsp_addr_pkg::ST_IDLE: begin
        if (accept && is_repeat) begin
          if (addr_mode == dsp_addr_pkg::MODE_DIRECT || addr_mode == dsp_addr_pkg::MODE_INDIRECT) begin
            state_nxt = dsp_addr_pkg::ST_CNT_LOAD;
          end else begin
            count_nxt = {8'h00, instr_word[dsp_addr_pkg::SHORT_IMM_LSB +: dsp_addr_pkg::SHORT_IMM_W]};
            state_nxt = dsp_addr_pkg::ST_ARMED;
          end
        end
      end
      dsp_addr_pkg::ST_CNT_LOAD: begin
        count_nxt = mem_rdata;
        state_nxt = dsp_addr_pkg::ST_ARMED;
      end
      dsp_addr_pkg::ST_ARMED: begin
        if (accept) begin
          held_word_nxt = instr_word;
          held_mode_nxt = addr_mode;
          held_ext_nxt = operand_ext;
          if (count_r == 16'h0000) begin
            state_nxt = dsp_addr_pkg::ST_IDLE;
          end else begin
            count_nxt = count_r - 16'h0001;
            state_nxt = dsp_addr_pkg::ST_LOOP;
          end
        end
      end
      dsp_addr_pkg::ST_LOOP: begin
        if (loop_issue) begin
          if (count_r == 16'h0000) begin
            state_nxt = dsp_addr_pkg::ST_IDLE;
          end else begin
            count_nxt = count_r - 16'h0001;
          end
        end
      end
      default: begin
        state_nxt = dsp_addr_pkg::ST_IDLE;
      end
    endcase
    ready_nxt = (wait_nxt == 2'h0) && (state_nxt != dsp_addr_pkg::ST_CNT_LOAD) &&
                (state_nxt != dsp_addr_pkg::ST_LOOP);
    active_nxt = (state_nxt != dsp_addr_pkg::ST_IDLE);
    // Masked from decode of the repeat to the end of its loop
    nmi_g_nxt = nmi_s2_r && !active_nxt && (state_r == dsp_addr_pkg::ST_IDLE) && !accept;
    irq_g_nxt = irq_s2_r && !nmi_s2_r && !active_nxt && (state_r == dsp_addr_pkg::ST_IDLE) && !accept;
  end

  always_ff @(posedge ref_clk) begin
    irq_s1_r <= irq_req_pin;
    irq_s2_r <= irq_s1_r;
    nmi_s1_r <= nmi_req_pin;
    nmi_s2_r <= nmi_s1_r;
    if (srst) begin
      state_r <= dsp_addr_pkg::ST_IDLE;
      count_r <= dsp_addr_pkg::COUNT_RST;
      held_word_r <= 16'h0000;
      held_mode_r <= 3'h0;
      held_ext_r <= 1'b0;
      wait_r <= 2'h0;
      ready_r <= 1'b0;
      active_r <= 1'b0;
      irq_g_r <= 1'b0;
      nmi_g_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      count_r <= count_nxt;
      held_word_r <= held_word_nxt;
      held_mode_r <= held_mode_nxt;
      held_ext_r <= held_ext_nxt;
      wait_r <= wait_nxt;
      ready_r <= ready_nxt;
      active_r <= active_nxt;
      irq_g_r <= irq_g_nxt;
      nmi_g_r <= nmi_g_nxt;
    end
  end

  assign instr_ready = ready_r;
  assign fetch_req = fetch_r;
  assign prog_addr = pc_r;
  assign data_addr = daddr_r;
  assign data_addr_valid = dvalid_r;
  assign imm_operand = imm_r;
  assign imm_valid = ivalid_r;
  assign iter_issue = issue_r;
  assign repeat_count_reg = count_r;
  assign repeat_active = active_r;
  assign aux_select_pointer = sel_r;
  assign data_page_pointer = page_r;
  assign irq_grant = irq_g_r;
  assign nmi_grant = nmi_g_r;

  // Checking: issues counted per repeat sequence
  logic [16:0] chk_n_r, chk_iss_r;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      chk_iss_r <= 17'h0_0000;
      chk_n_r <= 17'h0_0000;
    end else begin
      // Expected runs taken as the count enters the armed state
      if (state_nxt == dsp_addr_pkg::ST_ARMED && state_r != dsp_addr_pkg::ST_ARMED) begin
        chk_n_r <= {1'b0, count_nxt} + 17'h0_0001;
      end
      if (state_r == dsp_addr_pkg::ST_IDLE) begin
        chk_iss_r <= 17'h0_0000;
      end else if (issue) begin
        chk_iss_r <= chk_iss_r + 17'h0_0001;
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  a_direct_addr: assert property (issue && cur_mode == dsp_addr_pkg::MODE_DIRECT |=>
    data_addr_valid && data_addr[6:0] == $past(cur_word[6:0])) else $error("direct offset wrong");
  a_page_select: assert property (issue && cur_mode == dsp_addr_pkg::MODE_DIRECT |=>
    data_addr[15:7] == $past(page_r)) else $error("direct page wrong");
  a_indirect_addr: assert property (issue && cur_mode == dsp_addr_pkg::MODE_INDIRECT |=>
    data_addr == $past(cur_aux)) else $error("indirect address wrong");
  a_selector_load: assert property (issue && cur_mode == dsp_addr_pkg::MODE_INDIRECT && cur_word[3] |=>
    aux_select_pointer == $past(cur_word[2:0])) else $error("selector not loaded");
  a_aux_increment: assert property (issue && cur_mode == dsp_addr_pkg::MODE_INDIRECT &&
    cur_op == dsp_addr_pkg::IND_INC |=> aux_r[$past(sel_r)] == $past(cur_aux) + 16'h0001) else $error("no increment");
  a_long_words: assert property (accept && addr_mode == dsp_addr_pkg::MODE_LONG_IMM |=>
    imm_valid && imm_operand == $past(instr_ext_word) && prog_addr == $past(pc_r) + 16'h0002)
    else $error("long immediate form wrong");
  a_prefetch_next: assert property (accept |=> fetch_req) else $error("no prefetch");
  a_ext_stall: assert property (accept && operand_ext |=> !instr_ready [*2] ##1 instr_ready || repeat_active)
    else $error("external stall length wrong");
  a_short_count: assert property (accept && is_repeat && addr_mode == dsp_addr_pkg::MODE_SHORT_IMM |=>
    repeat_count_reg == {8'h00, $past(instr_word[7:0])}) else $error("short count not loaded");
  a_count_reset: assert property (disable iff (1'b0) srst |=> repeat_count_reg == 16'h0000)
    else $error("count not cleared");
  a_irq_masked: assert property (repeat_active |-> !irq_grant && !nmi_grant) else $error("interrupt in repeat");
  a_loop_rate: assert property (loop_issue |=> iter_issue) else $error("loop iteration missed");
  a_count_step: assert property (loop_issue && count_r != 16'h0000 |=>
    repeat_count_reg == $past(count_r) - 16'h0001) else $error("count step wrong");
  a_total_runs: assert property (state_r != dsp_addr_pkg::ST_IDLE && state_nxt == dsp_addr_pkg::ST_IDLE |->
    chk_iss_r + 17'h0_0001 == chk_n_r) else $error("repeat run count wrong");

  c_loop_done: cover property (state_r == dsp_addr_pkg::ST_LOOP ##1 state_r == dsp_addr_pkg::ST_IDLE);
  c_mem_count: cover property (state_r == dsp_addr_pkg::ST_CNT_LOAD);
  c_rev_add: cover property (issue && cur_mode == dsp_addr_pkg::MODE_INDIRECT && cur_op == dsp_addr_pkg::IND_REV_ADD0);
  c_ext_wait: cover property (accept && operand_ext);
endmodule : dsp_operand_addressing_repeat

// ### common/dsp_addr_pkg.sv
// Constants and types for operand address generation and instruction repeat
// Behaviour
// - In direct mode the low seven data address bits come from a field of the instruction word.
// - The direct address is the nine-bit page pointer placed above those seven bits, giving sixteen bits.
// - Direct mode divides data memory into 512 pages of 128 words, the page chosen only by the page pointer.
// - In indirect mode the selected auxiliary register supplies the operand address.
// - A three-bit selector picks one of eight auxiliary registers, value 0 to 7 meaning register zero to seven.
// - Indirect mode offers increment, decrement, add or subtract register zero, no change, and bit-reversed add or subtract.
// - Auxiliary arithmetic completes in the instruction's own cycle, after which register and selector may change.
// - Short immediates come from the single instruction word, long immediates from the second word.
// - An addition takes one program word with a short immediate and two with a long immediate.
// - The next instruction is fetched while the current one executes.
// - Execution takes longer when the operand fetch goes to external rather than internal memory.
// - The repeat instruction loads the counter from data memory in direct or indirect mode, or from an 8-bit immediate.
// - With N in the repeat counter the following instruction executes N plus one times.
// - Reset clears the repeat counter to zero.
// - From decode of the repeat instruction until its loop ends all interrupts, the nonmaskable one too, are held off.
// - Under repeat the repeated instruction issues one iteration per cycle when its operand is internal, one per three cycles when external.
package dsp_addr_pkg;
  localparam int DATA_W = 16;
  localparam int PAGE_W = 9;
  localparam int OFS_W = 7;
  localparam int NUM_AUX = 8;
  localparam int SEL_W = 3;
  localparam int SHORT_IMM_W = 8;
  localparam int OP_W = 3;
  // Instruction word fields
  localparam int OFS_LSB = 0;
  localparam int IND_OP_LSB = 4;
  localparam int SEL_LOAD_BIT = 3;
  localparam int NEXT_SEL_LSB = 0;
  localparam int SHORT_IMM_LSB = 0;
  // Program words per instruction form, and the auxiliary register step
  localparam logic [DATA_W-1:0] ONE_WORD = 16'h0001;
  localparam logic [DATA_W-1:0] TWO_WORDS = 16'h0002;
  localparam logic [DATA_W-1:0] AUX_STEP = 16'h0001;
  // Reset values
  localparam logic [DATA_W-1:0] COUNT_RST = 16'h0000;
  localparam logic [DATA_W-1:0] PC_RST = 16'h0000;
  localparam logic [PAGE_W-1:0] PAGE_RST = 9'h000;
  // External operand access time and its cycle count at 50 MHz
  localparam int CLK_PERIOD_NS = 20;
  localparam int EXT_ACCESS_NS = 40;
  localparam int EXT_WAIT_CYC_I = (EXT_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] EXT_WAIT_CYC = 2'(EXT_WAIT_CYC_I < 1 ? 1 : EXT_WAIT_CYC_I);

  typedef enum logic [2:0] {
    MODE_DIRECT = 3'h0,
    MODE_INDIRECT = 3'h1,
    MODE_SHORT_IMM = 3'h2,
    MODE_LONG_IMM = 3'h3,
    MODE_REGISTER = 3'h4
  } addr_mode_t;

  typedef enum logic [2:0] {
    IND_NONE = 3'h0,
    IND_INC = 3'h1,
    IND_DEC = 3'h2,
    IND_ADD0 = 3'h3,
    IND_SUB0 = 3'h4,
    IND_REV_ADD0 = 3'h5,
    IND_REV_SUB0 = 3'h6
  } ind_op_t;

  // Gray along idle, count load, armed, loop
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_CNT_LOAD = 2'h1,
    ST_ARMED = 2'h3,
    ST_LOOP = 2'h2
  } seq_state_t;
endpackage : dsp_addr_pkg

// ### test/dsp_operand_addressing_repeat_tb.sv
// Self-checking testbench for operand addressing and repeat control
`timescale 1ns/1ps
module dsp_operand_addressing_repeat_tb;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic instr_valid = 1'b0;
  logic [15:0] instr_word = 16'h0000;
  logic [15:0] instr_ext_word = 16'h0000;
  logic [2:0] addr_mode = 3'h0;
  logic is_repeat = 1'b0;
  logic operand_ext = 1'b0;
  logic page_load = 1'b0;
  logic [8:0] page_value = 9'h000;
  logic [15:0] mem_rdata = 16'h0000;
  logic irq_req_pin = 1'b0;
  logic nmi_req_pin = 1'b0;
  logic instr_ready, fetch_req, data_addr_valid, imm_valid, iter_issue, repeat_active, irq_grant, nmi_grant;
  logic [15:0] prog_addr, data_addr, imm_operand, repeat_count_reg;
  logic [2:0] aux_select_pointer;
  logic [8:0] data_page_pointer;
  int error_cnt = 0;
  int check_count = 0;
  int cyc = 0;
  logic [8:0] pg [3] = '{9'h1A5, 9'h1FF, 9'h000};
  logic [6:0] ofs [3] = '{7'h5B, 7'h7F, 7'h00};
  logic [2:0] iop [10] = '{3'h1, 3'h2, 3'h3, 3'h5, 3'h5, 3'h6, 3'h4, 3'h7, 3'h0, 3'h0};
  logic ild [10] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
  logic [2:0] isel [10] = '{3'h3, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0};
  logic [15:0] iadr [10] = '{16'h0000, 16'h0000, 16'hFFFF, 16'h0000, 16'h0001, 16'h0000, 16'h0001, 16'h0000,
    16'h0000, 16'h0001};
  logic [2:0] isx [10] = '{3'h3, 3'h3, 3'h3, 3'h3, 3'h3, 3'h3, 3'h3, 3'h3, 3'h0, 3'h0};

  dsp_operand_addressing_repeat uut (.ref_clk(ref_clk), .srst(srst), .instr_valid(instr_valid),
    .instr_word(instr_word), .instr_ext_word(instr_ext_word), .addr_mode(addr_mode), .is_repeat(is_repeat),
    .operand_ext(operand_ext), .page_load(page_load), .page_value(page_value), .mem_rdata(mem_rdata),
    .irq_req_pin(irq_req_pin), .nmi_req_pin(nmi_req_pin), .instr_ready(instr_ready), .fetch_req(fetch_req),
    .prog_addr(prog_addr), .data_addr(data_addr), .data_addr_valid(data_addr_valid), .imm_operand(imm_operand),
    .imm_valid(imm_valid), .iter_issue(iter_issue), .repeat_count_reg(repeat_count_reg),
    .repeat_active(repeat_active), .aux_select_pointer(aux_select_pointer),
    .data_page_pointer(data_page_pointer), .irq_grant(irq_grant), .nmi_grant(nmi_grant));

  always #10 ref_clk = ~ref_clk;

  function automatic logic [15:0] b16(input logic x);
    b16 = {15'h0000, x};
  endfunction : b16

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic print_verdict();
    if (error_cnt == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict

  // Cut a hang short
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end

  // Offer one instruction at a falling edge, return at the falling edge after it is taken
  task automatic issue(input logic [2:0] mode, input logic [15:0] w, input logic [15:0] ew, input logic rep,
    input logic ext);
    int n;
    n = 0;
    // Let the valid lowered by a previous call stand for one cycle
    @(negedge ref_clk);
    while (instr_ready !== 1'b1 && n < 50) begin
      @(negedge ref_clk);
      n++;
    end
    check("instr_ready", b16(instr_ready), 16'h0001);
    addr_mode = mode;
    instr_word = w;
    instr_ext_word = ew;
    is_repeat = rep;
    operand_ext = ext;
    instr_valid = 1'b1;
    @(posedge ref_clk);
    @(negedge ref_clk);
    instr_valid = 1'b0;
    is_repeat = 1'b0;
    operand_ext = 1'b0;
    check("fetch_req", b16(fetch_req), 16'h0001);
    check("iter_issue", b16(iter_issue), b16(~rep));
  endtask : issue

  task automatic run_rep(input logic [2:0] mode, input logic [15:0] cnt);
    int n;
    int iters;
    logic mem;
    mem = (mode == 3'h0 || mode == 3'h1);
    mem_rdata = cnt;
    issue(mode, mem ? 16'h005A : {8'h00, cnt[7:0]}, 16'h0000, 1'b1, 1'b0);
    n = 0;
    while (instr_ready !== 1'b1 && n < 10) begin
      @(negedge ref_clk);
      n++;
    end
    check("count_load", repeat_count_reg, cnt);
    check("active", b16(repeat_active), 16'h0001);
    irq_req_pin = 1'b1;
    nmi_req_pin = 1'b1;
    issue(3'h0, 16'h0011, 16'h0000, 1'b0, 1'b0);
    iters = 1;
    n = 0;
    while (repeat_active === 1'b1 && n < 300) begin
      check("grant_masked", {14'h0000, irq_grant, nmi_grant}, 16'h0000);
      @(negedge ref_clk);
      n++;
      if (iter_issue === 1'b1) begin
        iters++;
      end
    end
    check("iterations", 16'(iters), cnt + 16'h0001);
    check("one_per_cycle", 16'(n), cnt);
    @(negedge ref_clk);
    check("issue_stop", b16(iter_issue), 16'h0000);
    check("count_end", repeat_count_reg, 16'h0000);
    n = 0;
    while (nmi_grant !== 1'b1 && n < 10) begin
      @(negedge ref_clk);
      n++;
    end
    check("nmi_after", {14'h0000, irq_grant, nmi_grant}, 16'h0001);
    irq_req_pin = 1'b0;
    nmi_req_pin = 1'b0;
    repeat (6) @(negedge ref_clk);
  endtask : run_rep

  initial begin
    int n;
    repeat (5) @(negedge ref_clk);
    check("count_rst", repeat_count_reg, dsp_addr_pkg::COUNT_RST);
    check("ready_rst", b16(instr_ready), 16'h0000);
    srst = 1'b0;
    repeat (2) @(negedge ref_clk);
    for (int i = 0; i < 3; i++) begin
      page_value = pg[i];
      page_load = 1'b1;
      @(negedge ref_clk);
      page_load = 1'b0;
      check("page", {7'h00, data_page_pointer}, {7'h00, pg[i]});
      issue(3'h0, {9'h155, ofs[i]}, 16'h0000, 1'b0, 1'b0);
      check("direct_addr", data_addr, {pg[i], ofs[i]});
      check("direct_valid", b16(data_addr_valid), 16'h0001);
    end
    check("pc_direct", prog_addr, 16'h0003);
    issue(3'h2, 16'hA7C3, 16'h0000, 1'b0, 1'b0);
    check("short_imm", imm_operand, 16'h00C3);
    check("imm_valid", b16(imm_valid), 16'h0001);
    check("pc_short", prog_addr, 16'h0004);
    issue(3'h3, 16'h0011, 16'hBEEF, 1'b0, 1'b0);
    check("long_imm", imm_operand, 16'hBEEF);
    check("pc_long", prog_addr, 16'h0006);
    for (int i = 0; i < 10; i++) begin
      issue(3'h1, {9'h000, iop[i], ild[i], isel[i]}, 16'h0000, 1'b0, 1'b0);
      check("ind_addr", data_addr, iadr[i]);
      check("ind_sel", {13'h0000, aux_select_pointer}, {13'h0000, isx[i]});
    end
    issue(3'h0, 16'h0005, 16'h0000, 1'b0, 1'b1);
    n = 0;
    while (instr_ready !== 1'b1 && n < 10) begin
      @(negedge ref_clk);
      n++;
    end
    check("ext_wait", 16'(n), {14'h0000, dsp_addr_pkg::EXT_WAIT_CYC});
    irq_req_pin = 1'b1;
    repeat (6) @(negedge ref_clk);
    check("irq_idle", {14'h0000, irq_grant, nmi_grant}, 16'h0002);
    irq_req_pin = 1'b0;
    repeat (6) @(negedge ref_clk);
    run_rep(3'h2, 16'h0003);
    run_rep(3'h2, 16'h0000);
    run_rep(3'h2, 16'h00FF);
    run_rep(3'h0, 16'h0002);
    run_rep(3'h1, 16'h0004);
    run_rep(3'h4, 16'h0001);
    issue(3'h2, 16'h0005, 16'h0000, 1'b1, 1'b0);
    srst = 1'b1;
    repeat (2) @(negedge ref_clk);
    check("count_mid_rst", repeat_count_reg, 16'h0000);
    check("active_mid_rst", b16(repeat_active), 16'h0000);
    srst = 1'b0;
    repeat (2) @(negedge ref_clk);
    check("ready_after_rst", b16(instr_ready), 16'h0001);
    check("count_after_rst", repeat_count_reg, 16'h0000);
    print_verdict();
  end
endmodule : dsp_operand_addressing_repeat_tb
